/* rtl/stp_defs.svh */
// constants of the three-timer block: offsets, field positions, masks, counts
`ifndef STP_DEFS_SVH
`define STP_DEFS_SVH

// register indices on the plain register port
`define STP_ADDR_W            4
`define STP_REG_CTRL1         4'h0
`define STP_REG_PERIOD1       4'h1
`define STP_REG_COUNT1        4'h2
`define STP_REG_CTRL2         4'h3
`define STP_REG_PERIOD2       4'h4
`define STP_REG_COUNT2        4'h5
`define STP_REG_CTRL3         4'h6
`define STP_REG_PERIOD3       4'h7
`define STP_REG_COUNT3        4'h8
`define STP_REG_FLAGS         4'h9

// control field positions
`define STP_BIT_ON            15
`define STP_BIT_STOP_IDLE     13
`define STP_BIT_GATE_EN       6
`define STP_BIT_PRESC_HI      5
`define STP_BIT_PRESC_LO      4
`define STP_BIT_PAIR          3
`define STP_BIT_SYNC          2
`define STP_BIT_CLK_SRC       1

// implemented bits of each control register, the rest read as zero
`define STP_MASK_CTRL1        16'ha076
`define STP_MASK_CTRL2        16'ha07a
`define STP_MASK_CTRL3        16'ha072

// reset values
`define STP_CTRL_RST          16'h0000
`define STP_WORD_RST          16'h0000
`define STP_PERIOD_RST        16'hffff
`define STP_FLAGS_RST         3'h0

// timer indices
`define STP_T1                0
`define STP_T2                1
`define STP_T3                2
`define STP_NUM_TMR           3

// prescaler terminal counts: divide by 1, 8, 64, 256
`define STP_PRESC_W           8
`define STP_LIM_DIV1          8'h00
`define STP_LIM_DIV8          8'h07
`define STP_LIM_DIV64         8'h3f
`define STP_LIM_DIV256        8'hff

// instruction clock rate equals the system clock rate
`define STP_INSTR_CLK_HZ      50000000

`endif

/* rtl/stp_pkg.sv */
// types shared by the three-timer block
package stp_pkg;

	// timer control word, same layout for all three timers
	typedef struct packed {
		logic       timer_on;
		logic       rsv14;
		logic       stop_in_idle;
		logic [5:0] rsv12_7;
		logic       gated_accumulate_enable;
		logic [1:0] prescale_select;
		logic       pair_mode_select;
		logic       ext_clock_sync_select;
		logic       clock_source_select;
		logic       rsv0;
	} stp_ctrl_t;

	// prescale codes
	typedef enum logic [1:0] {
		STP_DIV1   = 2'h0,
		STP_DIV8   = 2'h1,
		STP_DIV64  = 2'h2,
		STP_DIV256 = 2'h3
	} stp_presc_t;

	// power state of the processor as seen by the timers
	typedef struct packed {
		logic idle;
		logic sleep;
	} stp_power_t;

endpackage

/* rtl/stp_prescaler.sv */
// input clock prescaler for one timer: 1:1, 1:8, 1:64 or 1:256
`timescale 1ns/1ps
`default_nettype none
`include "stp_defs.svh"

module stp_prescaler
	import stp_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_tick,
	input  wire logic       i_clear,
	input  wire stp_presc_t i_sel,
	output logic            o_tick
);

	logic [`STP_PRESC_W-1:0] cnt;
	logic [`STP_PRESC_W-1:0] limit;

	// terminal count chosen by the prescale code
	always_comb begin
		case (i_sel)
			STP_DIV1:   limit = `STP_LIM_DIV1;
			STP_DIV8:   limit = `STP_LIM_DIV8;
			STP_DIV64:  limit = `STP_LIM_DIV64;
			default:    limit = `STP_LIM_DIV256;
		endcase
	end

	// a tick leaves only on the input tick that reaches the terminal count
	assign o_tick = i_tick && !i_clear && (cnt >= limit);

	// cleared while the timer is stopped so every start begins a full divide
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= '0;
		end else if (i_clear || o_tick) begin
			cnt <= '0;
		end else if (i_tick) begin
			cnt <= cnt + `STP_PRESC_W'(1);
		end
	end

endmodule

`default_nettype wire

/* rtl/stp_timers.sv */
// three 16-bit timers, the second and third pairable into one 32-bit timer
//
// Overview of operation
// - first timer runs on internal clock, synchronised pin clock, or unsynchronised pin clock
// - first timer flags on period match or, gated, on gate falling edge
// - control bit 15 starts the timer when 1, stops it when 0
// - bit 13 set halts the timer in Idle; clear keeps it running
// - gate enable bit 6 acts only with the internal clock selected
// - prescale code 11 is 1:256, 10 is 1:64, 01 is 1:8, 00 is 1:1
// - first timer bit 2 synchronises the pin clock; ignored with internal clock; here the pin is synchronised either way, bit 2 only decides Sleep
// - bit 1 selects pin clock rising edges when 1, internal clock when 0
// - second and third timers offer every 16-bit mode except unsynchronised counting
// - second timer bit 3 joins second and third into one 32-bit timer
// - paired count: second timer holds low word, third timer high word
// - paired mode ignores third control bits; second timer control and pins rule
// - paired period match is reported through the third timer's flag
// - paired period: third period is high word, second period low word
// - paired interrupt fires when full 32-bit count equals full 32-bit period
// - only the paired timer drives the converter trigger
// - second and third counts are offered as time bases to capture/compare
// - paired, second timer on bit runs the whole 32-bit timer
// - second and third timers count own pin rising edges or internal clock
// - first timer may keep counting in Idle per stop-in-idle, and in Sleep only on the unsynchronised pin clock
`timescale 1ns/1ps
`default_nettype none
`include "stp_defs.svh"

module stp_timers
	import stp_pkg::*;
#(
	parameter int CNT_W = 16
)(
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_rst_n,
	input  wire logic [`STP_ADDR_W-1:0] i_addr,
	input  wire logic [CNT_W-1:0]       i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic      [CNT_W-1:0]       o_rdata,
	input  wire stp_power_t             i_power,
	input  wire logic                   i_first_timer_ext_clock_pin,
	input  wire logic                   i_second_timer_ext_clock_pin,
	input  wire logic                   i_third_timer_ext_clock_pin,
	output logic                        o_first_timer_irq_flag,
	output logic                        o_second_timer_irq_flag,
	output logic                        o_third_timer_irq_flag,
	output logic      [CNT_W-1:0]       o_second_timer_count,
	output logic      [CNT_W-1:0]       o_third_timer_count,
	output logic                        o_adc_trigger
);

	// register file
	stp_ctrl_t        ctrl    [`STP_NUM_TMR];
	logic [CNT_W-1:0] period  [`STP_NUM_TMR];
	logic [CNT_W-1:0] count   [`STP_NUM_TMR];
	logic [2:0]       flags;

	// pin synchronisers and edge detect
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	logic [2:0] pin_last;
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;

	// per-timer derived control
	stp_ctrl_t  eff       [`STP_NUM_TMR];
	logic       paired;
	logic [2:0] run;
	logic [2:0] raw_tick;
	logic [2:0] presc_tick;
	logic [2:0] gate_fall;
	logic [2:0] match16;
	logic       match32;
	logic [2:0] flag_set;
	logic [2:0] flag_clr;
	logic [CNT_W-1:0] rd_word;

	// decode a register write
	function automatic logic wr_hit(input logic [`STP_ADDR_W-1:0] addr,
					input logic [`STP_ADDR_W-1:0] reg_idx,
					input logic                   wr);
		wr_hit = wr && (addr == reg_idx);
	endfunction

	// next count after one counting clock; all three counters share it
	function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] v);
		step = v + CNT_W'(1);
	endfunction

	// may a timer advance in the present power state
	function automatic logic may_run(input stp_ctrl_t  c,
					 input stp_power_t p,
					 input logic       unsync_ext);
		logic idle_ok;
		logic sleep_ok;
		idle_ok  = !(c.stop_in_idle && p.idle);
		// only an unsynchronised pin clock survives the stopped system clock
		sleep_ok = !p.sleep || unsync_ext;
		may_run  = c.timer_on && idle_ok && sleep_ok;
	endfunction

	// pick the input tick from clock source and gate setting
	function automatic logic pick_tick(input stp_ctrl_t c,
					   input logic      rise,
					   input logic      level);
		if (c.clock_source_select) begin
			pick_tick = rise;
		end else if (c.gated_accumulate_enable) begin
			pick_tick = level;
		end else begin
			pick_tick = 1'b1;
		end
	endfunction

	// external pins pass two flip-flops; edge detect compares the second with a third
	// the unsynchronised first-timer mode shares these flops; it differs only in sleep
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_meta <= 3'h0;
			pin_sync <= 3'h0;
			pin_last <= 3'h0;
		end else begin
			pin_meta <= {i_third_timer_ext_clock_pin,
				     i_second_timer_ext_clock_pin,
				     i_first_timer_ext_clock_pin};
			pin_sync <= pin_meta;
			pin_last <= pin_sync;
		end
	end

	assign pin_rise = pin_sync & ~pin_last;
	assign pin_fall = ~pin_sync & pin_last;

	// paired mode hands the third timer over to the second timer's control
	assign paired = ctrl[`STP_T2].pair_mode_select;

	always_comb begin
		eff[`STP_T1] = ctrl[`STP_T1];
		eff[`STP_T2] = ctrl[`STP_T2];
		eff[`STP_T3] = paired ? ctrl[`STP_T2] : ctrl[`STP_T3];
	end

	// run enables; only the first timer has an unsynchronised pin path
	// the third timer is held while paired, so its own control bits change nothing
	always_comb begin
		run[`STP_T1] = may_run(eff[`STP_T1], i_power,
				       eff[`STP_T1].clock_source_select &&
				       !eff[`STP_T1].ext_clock_sync_select);
		run[`STP_T2] = may_run(eff[`STP_T2], i_power, 1'b0);
		run[`STP_T3] = may_run(eff[`STP_T3], i_power, 1'b0) && !paired;
	end

	// input ticks; the pin of the second timer feeds the pair
	always_comb begin
		for (int i = 0; i < `STP_NUM_TMR; i++) begin
			raw_tick[i]  = run[i] && pick_tick(eff[i], pin_rise[i], pin_sync[i]);
			gate_fall[i] = run[i] && !eff[i].clock_source_select &&
				       eff[i].gated_accumulate_enable && pin_fall[i];
		end
	end

	// one prescaler per timer, held clear while its timer is stopped
	genvar g;
	generate
		for (g = 0; g < `STP_NUM_TMR; g++) begin : g_presc
			stp_prescaler u_presc (
				.i_sys_clk (i_sys_clk),
				.i_rst_n   (i_rst_n),
				.i_tick    (raw_tick[g]),
				.i_clear   (!run[g]),
				.i_sel     (stp_presc_t'(eff[g].prescale_select)),
				.o_tick    (presc_tick[g])
			);
		end
	endgenerate

	// period matches; 16-bit compare is idle for the pair halves
	always_comb begin
		match16[`STP_T1] = presc_tick[`STP_T1] &&
				   (count[`STP_T1] == period[`STP_T1]);
		match16[`STP_T2] = presc_tick[`STP_T2] && !paired &&
				   (count[`STP_T2] == period[`STP_T2]);
		match16[`STP_T3] = presc_tick[`STP_T3] &&
				   (count[`STP_T3] == period[`STP_T3]);
	end

	// full-width compare; third period forms the high word
	// the low word passing its own period does not cut a paired count short
	assign match32 = paired && presc_tick[`STP_T2] &&
			 ({count[`STP_T3], count[`STP_T2]} ==
			  {period[`STP_T3], period[`STP_T2]});

	// control registers; writes to the third timer are kept but ignored when paired
	// unimplemented bits are dropped at the write, so they always read back zero
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl[`STP_T1] <= stp_ctrl_t'(`STP_CTRL_RST);
			ctrl[`STP_T2] <= stp_ctrl_t'(`STP_CTRL_RST);
			ctrl[`STP_T3] <= stp_ctrl_t'(`STP_CTRL_RST);
		end else begin
			if (wr_hit(i_addr, `STP_REG_CTRL1, i_wr)) begin
				ctrl[`STP_T1] <= stp_ctrl_t'(i_wdata & `STP_MASK_CTRL1);
			end
			if (wr_hit(i_addr, `STP_REG_CTRL2, i_wr)) begin
				ctrl[`STP_T2] <= stp_ctrl_t'(i_wdata & `STP_MASK_CTRL2);
			end
			if (wr_hit(i_addr, `STP_REG_CTRL3, i_wr)) begin
				ctrl[`STP_T3] <= stp_ctrl_t'(i_wdata & `STP_MASK_CTRL3);
			end
		end
	end

	// period registers
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			period[`STP_T1] <= `STP_PERIOD_RST;
			period[`STP_T2] <= `STP_PERIOD_RST;
			period[`STP_T3] <= `STP_PERIOD_RST;
		end else begin
			if (wr_hit(i_addr, `STP_REG_PERIOD1, i_wr)) begin
				period[`STP_T1] <= i_wdata;
			end
			if (wr_hit(i_addr, `STP_REG_PERIOD2, i_wr)) begin
				period[`STP_T2] <= i_wdata;
			end
			if (wr_hit(i_addr, `STP_REG_PERIOD3, i_wr)) begin
				period[`STP_T3] <= i_wdata;
			end
		end
	end

	// first timer count; a software write wins over counting in the same cycle
	// a write while running restarts the period from the written value
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count[`STP_T1] <= `STP_WORD_RST;
		end else if (wr_hit(i_addr, `STP_REG_COUNT1, i_wr)) begin
			count[`STP_T1] <= i_wdata;
		end else if (match16[`STP_T1]) begin
			count[`STP_T1] <= `STP_WORD_RST;
		end else if (presc_tick[`STP_T1]) begin
			count[`STP_T1] <= step(count[`STP_T1]);
		end
	end

	// second timer: low word of the pair or a timer of its own
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count[`STP_T2] <= `STP_WORD_RST;
		end else if (wr_hit(i_addr, `STP_REG_COUNT2, i_wr)) begin
			count[`STP_T2] <= i_wdata;
		end else if (match16[`STP_T2] || match32) begin
			count[`STP_T2] <= `STP_WORD_RST;
		end else if (presc_tick[`STP_T2]) begin
			count[`STP_T2] <= step(count[`STP_T2]);
		end
	end

	// third timer: high word advances on the low word's carry when paired
	// the carry comes from the low word's own tick so both halves move on one edge
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count[`STP_T3] <= `STP_WORD_RST;
		end else if (wr_hit(i_addr, `STP_REG_COUNT3, i_wr)) begin
			count[`STP_T3] <= i_wdata;
		end else if (match16[`STP_T3] || match32) begin
			count[`STP_T3] <= `STP_WORD_RST;
		end else if (paired && presc_tick[`STP_T2] && (&count[`STP_T2])) begin
			count[`STP_T3] <= step(count[`STP_T3]);
		end else if (presc_tick[`STP_T3]) begin
			count[`STP_T3] <= step(count[`STP_T3]);
		end
	end

	// flag sources; the pair reports through the third flag only
	always_comb begin
		flag_set[`STP_T1] = match16[`STP_T1] || gate_fall[`STP_T1];
		flag_set[`STP_T2] = !paired &&
				    (match16[`STP_T2] || gate_fall[`STP_T2]);
		flag_set[`STP_T3] = match16[`STP_T3] || gate_fall[`STP_T3] ||
				    match32 || (paired && gate_fall[`STP_T2]);
		// write-one-to-clear, so rewriting other bits never drops a pending flag
		flag_clr = wr_hit(i_addr, `STP_REG_FLAGS, i_wr) ?
			   i_wdata[`STP_NUM_TMR-1:0] : `STP_FLAGS_RST;
	end

	// sticky flags cleared by writing one; a set in the same cycle wins
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flags <= `STP_FLAGS_RST;
		end else begin
			flags <= (flags & ~flag_clr) | flag_set;
		end
	end

	assign o_first_timer_irq_flag  = flags[`STP_T1];
	assign o_second_timer_irq_flag = flags[`STP_T2];
	assign o_third_timer_irq_flag  = flags[`STP_T3];

	// converter start pulse, one cycle after a full-width match
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_adc_trigger <= 1'b0;
		end else begin
			o_adc_trigger <= match32;
		end
	end

	// time bases for capture and compare come straight from the counters
	// no latch across the pair: reading the halves apart can straddle a carry
	assign o_second_timer_count = count[`STP_T2];
	assign o_third_timer_count  = count[`STP_T3];

	// read decode; unmapped addresses read as zero
	always_comb begin
		case (i_addr)
			`STP_REG_CTRL1:   rd_word = ctrl[`STP_T1] & `STP_MASK_CTRL1;
			`STP_REG_PERIOD1: rd_word = period[`STP_T1];
			`STP_REG_COUNT1:  rd_word = count[`STP_T1];
			`STP_REG_CTRL2:   rd_word = ctrl[`STP_T2] & `STP_MASK_CTRL2;
			`STP_REG_PERIOD2: rd_word = period[`STP_T2];
			`STP_REG_COUNT2:  rd_word = count[`STP_T2];
			`STP_REG_CTRL3:   rd_word = ctrl[`STP_T3] & `STP_MASK_CTRL3;
			`STP_REG_PERIOD3: rd_word = period[`STP_T3];
			`STP_REG_COUNT3:  rd_word = count[`STP_T3];
			`STP_REG_FLAGS:   rd_word = {{(CNT_W-`STP_NUM_TMR){1'b0}}, flags};
			default:          rd_word = '0;
		endcase
	end

	// read data stand only in the cycle after the strobe
	// zero outside the answer cycle keeps a stale word off a shared return path
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= `STP_WORD_RST;
		end else begin
			o_rdata <= i_rd ? rd_word : `STP_WORD_RST;
		end
	end

endmodule

`default_nettype wire

/* tb/stp_timers_bench.sv */
// self-checking bench for the three-timer block
`timescale 1ns/1ps
`default_nettype none
`include "stp_defs.svh"
module stp_timers_bench
	import stp_pkg::*;
;
	logic        clk;
	logic        rst_n;
	logic [3:0]  addr;
	logic [15:0] wdata;
	logic        wr_s;
	logic        rd_s;
	stp_power_t  power;
	logic [2:0]  pin;
	logic [15:0] rdata;
	logic [15:0] cnt2;
	logic [15:0] cnt3;
	logic [2:0]  flag;
	logic        adc;
	int          adc_n = 0;
	int          n_errors = 0;
	int          check_count = 0;
	int          div [4] = '{1, 8, 64, 256};
	logic [15:0] msk [3] = '{16'ha076, 16'ha07a, 16'ha072};
	logic [15:0] ectl [3] = '{16'h8046, 16'h8002, 16'h8006};
	logic [15:0] ecnt [3] = '{16'h0005, 16'h0005, 16'h0000};

	stp_timers uut (
		.i_sys_clk(clk),
		.i_rst_n(rst_n),
		.i_addr(addr),
		.i_wdata(wdata),
		.i_wr(wr_s),
		.i_rd(rd_s),
		.o_rdata(rdata),
		.i_power(power),
		.i_first_timer_ext_clock_pin(pin[0]),
		.i_second_timer_ext_clock_pin(pin[1]),
		.i_third_timer_ext_clock_pin(pin[2]),
		.o_first_timer_irq_flag(flag[0]),
		.o_second_timer_irq_flag(flag[1]),
		.o_third_timer_irq_flag(flag[2]),
		.o_second_timer_count(cnt2),
		.o_third_timer_count(cnt3),
		.o_adc_trigger(adc)
	);

	// free-running system clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// count trigger pulses, since each stands for one cycle only
	always @(posedge clk) begin
		if (adc === 1'b1) begin
			adc_n++;
		end
	end

	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
		check_count++;
		if (got !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, got);
		end
	endtask

	// a clock edge passes after each access so strobes never re-rise in one step
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		// read data stand only until the next edge; look mid-cycle
		@(negedge clk);
		chk($sformatf("reg %0h", a), e, rdata);
		@(posedge clk);
	endtask

	// timer on for exactly k counting edges
	task automatic run(input logic [3:0] a, input logic [15:0] c, input int k);
		wr(a, c);
		repeat (k - 2) @(posedge clk);
		wr(a, 16'h0000);
	endtask

	task automatic pulse(input int p, input int n);
		repeat (n) begin
			pin[p] <= 1'b1;
			repeat (3) @(posedge clk);
			pin[p] <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// watchdog: the sequence needs under fifteen hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("MISMATCH watchdog expected finish seen hang");
		tally_and_finish;
	end

	initial begin
		rst_n = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		wr_s = 1'b0;
		rd_s = 1'b0;
		power = '0;
		pin = 3'h0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		// reset values: periods all ones, the rest zero
		for (int i = 0; i < 10; i++) begin
			rd(i[3:0], (i % 3 == 1) ? 16'hffff : 16'h0000);
		end
		wr(4'hf, 16'hffff);
		rd(4'hf, 16'h0000);
		// only implemented control bits hold a one
		for (int i = 0; i < 3; i++) begin
			wr(4'(3 * i), 16'hffff);
			rd(4'(3 * i), msk[i]);
			wr(4'(3 * i), 16'h0000);
		end
		// period 2 repeats every three ticks
		wr(`STP_REG_PERIOD1, 16'h0002);
		run(`STP_REG_CTRL1, 16'h8000, 7);
		rd(`STP_REG_COUNT1, 16'h0001);
		chk("flag1", 16'h0001, {15'h0, flag[0]});
		wr(`STP_REG_PERIOD1, 16'hffff);
		// every prescale code over three divided periods
		for (int c = 0; c < 4; c++) begin
			wr(`STP_REG_COUNT1, 16'h0000);
			run(`STP_REG_CTRL1, 16'h8000 | {10'h0, c[1:0], 4'h0}, 3 * div[c]);
			rd(`STP_REG_COUNT1, 16'h0003);
		end
		// gated accumulation: hold while low, count while high, flag on fall
		wr(`STP_REG_COUNT1, 16'h0000);
		wr(`STP_REG_FLAGS, 16'h0007);
		wr(`STP_REG_CTRL1, 16'h8040);
		repeat (6) @(posedge clk);
		rd(`STP_REG_COUNT1, 16'h0000);
		pin[0] <= 1'b1;
		repeat (10) @(posedge clk);
		pin[0] <= 1'b0;
		repeat (6) @(posedge clk);
		chk("gate flag", 16'h0001, {15'h0, flag[0]});
		wr(`STP_REG_CTRL1, 16'h0000);
		rd(`STP_REG_COUNT1, 16'h000a);
		// pin clock: gate ignored; unsynchronised keeps counting in sleep
		for (int i = 0; i < 3; i++) begin
			power <= '{idle: 1'b0, sleep: (i > 0)};
			wr(`STP_REG_COUNT1, 16'h0000);
			wr(`STP_REG_CTRL1, ectl[i]);
			pulse(0, 5);
			wr(`STP_REG_CTRL1, 16'h0000);
			rd(`STP_REG_COUNT1, ecnt[i]);
		end
		// stop-in-idle halts the second timer, clear lets it run
		power <= '{idle: 1'b1, sleep: 1'b0};
		wr(`STP_REG_COUNT2, 16'h0000);
		wr(`STP_REG_CTRL2, 16'ha000);
		repeat (5) @(posedge clk);
		chk("idle hold", 16'h0000, cnt2);
		wr(`STP_REG_CTRL2, 16'h8000);
		wr(`STP_REG_CTRL2, 16'h0000);
		chk("idle run", 16'h0002, cnt2);
		power <= '0;
		// second and third timers count their own pins
		for (int i = 1; i < 3; i++) begin
			wr(4'(3 * i + 2), 16'h0000);
			wr(4'(3 * i), 16'h8002);
			pulse(i, 4);
			wr(4'(3 * i), 16'h0000);
			rd(4'(3 * i + 2), 16'h0004);
		end
		// unpaired match flags the second timer but never triggers
		wr(`STP_REG_PERIOD2, 16'h0001);
		wr(`STP_REG_COUNT2, 16'h0000);
		wr(`STP_REG_CTRL2, 16'h8000);
		repeat (6) @(posedge clk);
		wr(`STP_REG_CTRL2, 16'h0000);
		chk("flag2", 16'h0001, {15'h0, flag[1]});
		chk("adc unpaired", 16'h0000, 16'(adc_n));
		// paired: low word match alone must not fire; third control ignored
		wr(`STP_REG_FLAGS, 16'h0007);
		wr(`STP_REG_PERIOD2, 16'h0002);
		wr(`STP_REG_PERIOD3, 16'h0001);
		wr(`STP_REG_CTRL2, 16'h0008);
		wr(`STP_REG_CTRL3, 16'h8000);
		wr(`STP_REG_COUNT3, 16'h0000);
		wr(`STP_REG_COUNT2, 16'h0000);
		wr(`STP_REG_CTRL2, 16'h8008);
		repeat (8) @(posedge clk);
		chk("early flag3", 16'h0000, {15'h0, flag[2]});
		chk("third ignored", 16'h0000, cnt3);
		wr(`STP_REG_COUNT2, 16'hfffd);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("carry high", 16'h0001, cnt3);
		chk("carry low", 16'h0000, cnt2);
		repeat (6) @(posedge clk);
		chk("pair flag3", 16'h0001, {15'h0, flag[2]});
		chk("pair flag2", 16'h0000, {15'h0, flag[1]});
		chk("adc paired", 16'h0001, 16'(adc_n));
		// second on bit stops the whole pair, third on bit notwithstanding
		wr(`STP_REG_CTRL2, 16'h0008);
		wr(`STP_REG_COUNT2, 16'hffff);
		wr(`STP_REG_COUNT3, 16'h0000);
		repeat (4) @(posedge clk);
		chk("pair off", 16'h0000, cnt3);
		chk("pair off low", 16'hffff, cnt2);
		wr(`STP_REG_CTRL3, 16'h0000);
		wr(`STP_REG_CTRL2, 16'h0000);
		tally_and_finish;
	end
endmodule

bind stp_timers stp_timers_sva #(.CNT_W(CNT_W)) u_sva (.*);
`default_nettype wire

/* tb/stp_timers_sva.sv */
// port-level property checker for the three-timer block
`timescale 1ns/1ps
`default_nettype none
`include "stp_defs.svh"
module stp_timers_sva
	import stp_pkg::*;
#(
	parameter int CNT_W = 16
)(
	input wire logic                   i_sys_clk,
	input wire logic                   i_rst_n,
	input wire logic [`STP_ADDR_W-1:0] i_addr,
	input wire logic [CNT_W-1:0]       i_wdata,
	input wire logic                   i_wr,
	input wire logic                   i_rd,
	input wire logic [CNT_W-1:0]       o_rdata,
	input wire stp_power_t             i_power,
	input wire logic                   o_first_timer_irq_flag,
	input wire logic                   o_second_timer_irq_flag,
	input wire logic                   o_third_timer_irq_flag,
	input wire logic [CNT_W-1:0]       o_second_timer_count,
	input wire logic [CNT_W-1:0]       o_third_timer_count,
	input wire logic                   o_adc_trigger
);
	logic on2;
	logic sidl2;
	logic pair2;

	// shadow of the second control bits, so checks can see the mode
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{on2, sidl2, pair2} <= 3'h0;
		end else if (i_wr && i_addr == `STP_REG_CTRL2) begin
			{on2, sidl2, pair2} <= {i_wdata[`STP_BIT_ON],
						i_wdata[`STP_BIT_STOP_IDLE],
						i_wdata[`STP_BIT_PAIR]};
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	// a read of the second count, answered one cycle later
	sequence s_rd_count2;
		i_rd && i_addr == `STP_REG_COUNT2;
	endsequence

	a_rd_count2: assert property (s_rd_count2 |=> o_rdata == $past(o_second_timer_count))
		else $error("second count read back wrong");
	a_off_frozen: assert property ((!$past(on2) && !$past(i_wr)) |-> $stable(o_second_timer_count))
		else $error("second count moved while off");
	a_idle_frozen: assert property (($past(i_power.idle) && $past(sidl2) && !$past(i_wr))
		|-> $stable(o_second_timer_count))
		else $error("second count moved in idle");
	a_count_step: assert property (($changed(o_second_timer_count) && !$past(i_wr))
		|-> (o_second_timer_count == $past(o_second_timer_count) + 16'h0001)
		|| (o_second_timer_count == 16'h0000))
		else $error("second count jumped");
	a_carry_low: assert property (($changed(o_third_timer_count) && $past(pair2) && !$past(i_wr))
		|-> o_second_timer_count == 16'h0000)
		else $error("high word moved without low wrap");
	a_flag2_paired: assert property ($rose(o_second_timer_irq_flag) |-> !$past(pair2))
		else $error("second flag set while paired");
	a_adc_paired: assert property (o_adc_trigger |-> $past(pair2))
		else $error("converter trigger while unpaired");
	a_adc_flag3: assert property (o_adc_trigger |-> o_third_timer_irq_flag)
		else $error("converter trigger without third flag");
	a_flag1_sticky: assert property ($fell(o_first_timer_irq_flag)
		|-> $past(i_wr) && $past(i_addr) == `STP_REG_FLAGS && $past(i_wdata[0]))
		else $error("first flag dropped without clear");
endmodule
`default_nettype wire
